// File: hw/atf_cmd_handler.sv
// Task-file command handler: APB registers, opcode decode and execution
// of power query, erase, diagnostics, flush and identify.
// Assumes a media engine that answers each request with one done pulse.
`timescale 1ns/1ps

// Functional notes
// - Power query in standby: busy, sector count 00h, clear busy, interrupt.
// - Power query in idle: busy, sector count FFh, clear busy, interrupt.
// - Erase start address taken from drive/head, cylinder and sector regs.
// - Erase sector count register gives the number of sectors to erase.
// - Erase moves no data but may end with a write-fault status.
// - Erase leaves sectors pre-conditioned for later writes without erase.
// - Diagnostic ignores drive select; master reports status for both.
// - Diagnostic result code lands in the error register.
// - Flush writes cache to media, then status shows ready and seek done.
// - Without flush support the command ends as command aborted.
// - Identify returns parameter block with single-sector read protocol.
// - Reserved identify bits and words read as zero.
module atf_cmd_handler
  import atf_pkg::*;
#(
  parameter bit FLUSH_SUPPORTED = 1'b1,
  parameter bit DEVICE_ID = 1'b0,
  parameter logic [27:0] CAPACITY = 28'h0100000,
  parameter logic [15:0] ID_CONFIG = 16'h044a
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standbyState,
  input wire logic slaveDiagFail,
  output atf_media_req_t mediaReq,
  output logic mediaReqValid,
  input wire atf_media_rsp_t mediaRsp,
  output logic irq
);

  typedef enum logic [2:0] {
    ATF_IDLE,
    ATF_EXEC,
    ATF_MEDIA,
    ATF_DATA,
    ATF_FINISH
  } atf_state_t;

  atf_state_t state_reg, state_next;
  logic [7:0] feature_reg, secCnt_reg, secNum_reg;
  logic [7:0] cylLow_reg, cylHigh_reg, drvHead_reg;
  logic [7:0] opcode_reg;
  logic [7:0] status_reg, status_next;
  logic [7:0] error_reg, error_next;
  logic [7:0] secCntCmd_next;
  logic secCntLoad;
  logic [7:0] wordIdx_reg, wordIdx_next;
  logic [2:0] irqStat_reg, irqEn_reg;
  logic [2:0] irqSet;
  atf_media_req_t mediaReq_reg, mediaReq_next;
  logic mediaReqValid_reg, mediaReqValid_next;

  // Parameter block, one word at a time; words not listed are zero
  function automatic logic [15:0] atf_id_word(input logic [7:0] idx);
    case (idx)
      8'd0: atf_id_word = ID_CONFIG;
      8'd7: atf_id_word = {4'h0, CAPACITY[27:16]};
      8'd8: atf_id_word = CAPACITY[15:0];
      8'd20: atf_id_word = 16'h0002;
      8'd47: atf_id_word = 16'h8001;
      8'd49: atf_id_word = 16'h0f00;
      8'd50: atf_id_word = 16'h4000;
      8'd51: atf_id_word = 16'h0200;
      8'd53: atf_id_word = 16'h0007;
      8'd60: atf_id_word = CAPACITY[15:0];
      8'd61: atf_id_word = {4'h0, CAPACITY[27:16]};
      8'd64: atf_id_word = 16'h0003;
      default: atf_id_word = 16'h0000;
    endcase
  endfunction

  // APB decode; slave never inserts wait states
  wire logic apbWrite = psel & penable & pwrite;
  wire logic apbRead = psel & penable & ~pwrite;
  wire logic hitFeature = paddr == OFF_FEATURE;
  wire logic hitSecCnt = paddr == OFF_SECCNT;
  wire logic hitSecNum = paddr == OFF_SECNUM;
  wire logic hitCylLow = paddr == OFF_CYLLOW;
  wire logic hitCylHigh = paddr == OFF_CYLHIGH;
  wire logic hitDrvHead = paddr == OFF_DRVHEAD;
  wire logic hitOpcode = paddr == OFF_OPCODE;
  wire logic hitStatus = paddr == OFF_STATUS;
  wire logic hitError = paddr == OFF_ERROR;
  wire logic hitData = paddr == OFF_DATA;
  wire logic hitIrqStat = paddr == OFF_IRQSTAT;
  wire logic hitIrqClr = paddr == OFF_IRQCLR;
  wire logic hitIrqEn = paddr == OFF_IRQEN;
  wire logic hitAny = hitFeature | hitSecCnt | hitSecNum | hitCylLow |
    hitCylHigh | hitDrvHead | hitOpcode | hitStatus | hitError | hitData |
    hitIrqStat | hitIrqClr | hitIrqEn;
  wire logic lane0 = pstrb[0];
  wire logic busy = status_reg[ST_BUSY];
  // Task file locked while busy so a running command sees stable inputs
  wire logic tfWrite = apbWrite & lane0 & ~busy & ~status_reg[ST_DRQ];
  wire logic opcodeWrite = tfWrite & hitOpcode;
  wire logic dataPop = apbRead & hitData & status_reg[ST_DRQ];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  // Opcode classification
  wire logic isPwr = (opcode_reg == OP_PWR_A) | (opcode_reg == OP_PWR_B);
  wire logic isErase = opcode_reg == OP_ERASE;
  wire logic isDiag = opcode_reg == OP_DIAG;
  wire logic isFlush = opcode_reg == OP_FLUSH;
  wire logic isIdent = opcode_reg == OP_IDENT;
  // Drive select only; head bits play no part here
  wire logic devMatch = drvHead_reg[DH_DEV] == DEVICE_ID;
  wire logic [27:0] startLba = {drvHead_reg[3:0], cylHigh_reg,
    cylLow_reg, secNum_reg};

  // Read data mux
  wire logic [15:0] idWord = atf_id_word(wordIdx_reg);
  always_comb begin
    prdata = 32'h0000_0000;
    if (apbRead) begin
      case (1'b1)
        hitFeature: prdata = {24'h0, feature_reg};
        hitSecCnt: prdata = {24'h0, secCnt_reg};
        hitSecNum: prdata = {24'h0, secNum_reg};
        hitCylLow: prdata = {24'h0, cylLow_reg};
        hitCylHigh: prdata = {24'h0, cylHigh_reg};
        hitDrvHead: prdata = {24'h0, drvHead_reg};
        hitStatus: prdata = {24'h0, status_reg};
        hitError: prdata = {24'h0, error_reg};
        hitData: prdata = status_reg[ST_DRQ] ? {16'h0, idWord} : 32'h0;
        hitIrqStat: prdata = {29'h0, irqStat_reg};
        hitIrqEn: prdata = {29'h0, irqEn_reg};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Command sequencer
  always_comb begin
    state_next = state_reg;
    status_next = status_reg;
    error_next = error_reg;
    secCntCmd_next = secCnt_reg;
    secCntLoad = 1'b0;
    wordIdx_next = wordIdx_reg;
    mediaReq_next = mediaReq_reg;
    mediaReqValid_next = 1'b0;
    irqSet = 3'b000;
    case (state_reg)
      ATF_IDLE: begin
        if (opcodeWrite) begin
          status_next[ST_BUSY] = 1'b1;
          status_next[ST_ERR] = 1'b0;
          status_next[ST_WF] = 1'b0;
          status_next[ST_DSC] = 1'b0;
          error_next = 8'h00;
          state_next = ATF_EXEC;
        end
      end
      ATF_EXEC: begin
        if (!devMatch && !isDiag) begin
          // Addressed to the other drive: drop quietly
          status_next[ST_BUSY] = 1'b0;
          status_next[ST_DSC] = 1'b1;
          state_next = ATF_IDLE;
        end else if (isPwr) begin
          secCntLoad = 1'b1;
          secCntCmd_next = standbyState ? PWR_STANDBY : PWR_IDLE;
          state_next = ATF_FINISH;
        end else if (isErase) begin
          mediaReq_next.op = ATF_MOP_ERASE;
          mediaReq_next.lba = startLba;
          mediaReq_next.count = secCnt_reg;
          mediaReq_next.lbaMode = drvHead_reg[DH_LBA];
          mediaReqValid_next = 1'b1;
          state_next = ATF_MEDIA;
        end else if (isDiag) begin
          mediaReq_next = '0;
          mediaReq_next.op = ATF_MOP_DIAG;
          mediaReqValid_next = 1'b1;
          state_next = ATF_MEDIA;
        end else if (isFlush && FLUSH_SUPPORTED) begin
          mediaReq_next = '0;
          mediaReq_next.op = ATF_MOP_FLUSH;
          mediaReqValid_next = 1'b1;
          state_next = ATF_MEDIA;
        end else if (isIdent) begin
          // Same handshake as a one-sector read
          wordIdx_next = 8'h00;
          status_next[ST_BUSY] = 1'b0;
          status_next[ST_DRQ] = 1'b1;
          irqSet[IRQ_DATA] = 1'b1;
          state_next = ATF_DATA;
        end else begin
          // Unsupported opcode, or flush without support
          error_next[ER_ABRT] = 1'b1;
          status_next[ST_ERR] = 1'b1;
          irqSet[IRQ_ERR] = 1'b1;
          state_next = ATF_FINISH;
        end
      end
      ATF_MEDIA: begin
        if (mediaRsp.done) begin
          if (mediaReq_reg.op == ATF_MOP_DIAG) begin
            error_next = mediaRsp.diagCode |
              (slaveDiagFail ? DIAG_SLAVE_FAIL : 8'h00);
            status_next[ST_ERR] = mediaRsp.diagCode != DIAG_OK;
          end else if (mediaRsp.fault) begin
            status_next[ST_WF] = 1'b1;
            status_next[ST_ERR] = 1'b1;
            irqSet[IRQ_ERR] = 1'b1;
          end
          state_next = ATF_FINISH;
        end
      end
      ATF_DATA: begin
        if (dataPop) begin
          wordIdx_next = wordIdx_reg + 8'h01;
          if (wordIdx_reg == ID_LAST_WORD) begin
            status_next[ST_DRQ] = 1'b0;
            status_next[ST_DSC] = 1'b1;
            irqSet[IRQ_DONE] = 1'b1;
            state_next = ATF_IDLE;
          end
        end
      end
      ATF_FINISH: begin
        status_next[ST_BUSY] = 1'b0;
        status_next[ST_RDY] = 1'b1;
        status_next[ST_DSC] = 1'b1;
        irqSet[IRQ_DONE] = 1'b1;
        state_next = ATF_IDLE;
      end
      default: begin
        state_next = ATF_IDLE;
      end
    endcase
  end

  // Task-file registers; sector count can also be loaded by a command
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      feature_reg <= RST_TASKFILE;
      secCnt_reg <= RST_TASKFILE;
      secNum_reg <= RST_TASKFILE;
      cylLow_reg <= RST_TASKFILE;
      cylHigh_reg <= RST_TASKFILE;
      drvHead_reg <= RST_TASKFILE;
      opcode_reg <= RST_TASKFILE;
    end else begin
      if (tfWrite && hitFeature) feature_reg <= pwdata[7:0];
      if (secCntLoad) secCnt_reg <= secCntCmd_next;
      else if (tfWrite && hitSecCnt) secCnt_reg <= pwdata[7:0];
      if (tfWrite && hitSecNum) secNum_reg <= pwdata[7:0];
      if (tfWrite && hitCylLow) cylLow_reg <= pwdata[7:0];
      if (tfWrite && hitCylHigh) cylHigh_reg <= pwdata[7:0];
      if (tfWrite && hitDrvHead) drvHead_reg <= pwdata[7:0];
      if (opcodeWrite) opcode_reg <= pwdata[7:0];
    end
  end

  // Sequencer state and command results
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ATF_IDLE;
      status_reg <= RST_STATUS;
      error_reg <= DIAG_OK;
      wordIdx_reg <= 8'h00;
      mediaReq_reg <= '0;
      mediaReqValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      status_reg <= status_next;
      error_reg <= error_next;
      wordIdx_reg <= wordIdx_next;
      mediaReq_reg <= mediaReq_next;
      mediaReqValid_reg <= mediaReqValid_next;
    end
  end

  assign mediaReq = mediaReq_reg;
  assign mediaReqValid = mediaReqValid_reg;

  // Interrupt status: a new event beats a clear in the same cycle
  wire logic [2:0] irqClr = (apbWrite && hitIrqClr && lane0) ?
    pwdata[2:0] : 3'b000;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= 3'b000;
      irqEn_reg <= RST_IRQEN;
    end else begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      if (apbWrite && hitIrqEn && lane0) irqEn_reg <= pwdata[2:0];
    end
  end

  assign irq = |(irqStat_reg & irqEn_reg);

endmodule

// File: hw/atf_pkg.sv
// Package for the task-file command handler: register map, field
// positions, opcodes, result codes and the media request carrier.
// Assumes a 32-bit APB register bus with one register per aligned word.
package atf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_FEATURE = 8'h00;
  localparam logic [7:0] OFF_SECCNT = 8'h04;
  localparam logic [7:0] OFF_SECNUM = 8'h08;
  localparam logic [7:0] OFF_CYLLOW = 8'h0c;
  localparam logic [7:0] OFF_CYLHIGH = 8'h10;
  localparam logic [7:0] OFF_DRVHEAD = 8'h14;
  localparam logic [7:0] OFF_OPCODE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_ERROR = 8'h20;
  localparam logic [7:0] OFF_DATA = 8'h24;
  localparam logic [7:0] OFF_IRQSTAT = 8'h28;
  localparam logic [7:0] OFF_IRQCLR = 8'h2c;
  localparam logic [7:0] OFF_IRQEN = 8'h30;

  // Reset values
  localparam logic [7:0] RST_TASKFILE = 8'h00;
  localparam logic [2:0] RST_IRQEN = 3'h0;
  localparam logic [7:0] RST_STATUS = 8'h50;

  // Status register bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_WF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;

  // Error register: command aborted bit
  localparam int ER_ABRT = 2;

  // Drive/head fields
  localparam int DH_DEV = 4;
  localparam int DH_LBA = 6;

  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DATA = 1;
  localparam int IRQ_ERR = 2;

  // Opcodes
  localparam logic [7:0] OP_PWR_A = 8'h98;
  localparam logic [7:0] OP_PWR_B = 8'he5;
  localparam logic [7:0] OP_ERASE = 8'hc0;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_FLUSH = 8'he7;
  localparam logic [7:0] OP_IDENT = 8'hec;

  // Power mode answers in the sector count
  localparam logic [7:0] PWR_STANDBY = 8'h00;
  localparam logic [7:0] PWR_IDLE = 8'hff;

  // Diagnostic result codes
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;

  // Index of the last word of the identify block
  localparam logic [7:0] ID_LAST_WORD = 8'hff;

  // Media engine operations
  typedef enum logic [1:0] {
    ATF_MOP_ERASE,
    ATF_MOP_FLUSH,
    ATF_MOP_DIAG
  } atf_mop_t;

  // Request to the media engine
  typedef struct packed {
    atf_mop_t op;
    logic [27:0] lba;
    logic [7:0] count;
    logic lbaMode;
  } atf_media_req_t;

  // Answer of the media engine
  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] diagCode;
  } atf_media_rsp_t;

endpackage

// File: tb/atf_cmd_handler_sva.sv
// Port checker for the task-file command handler.
// Sees only the handler ports; bound to every handler instance.
`timescale 1ns/1ps
module atf_cmd_handler_sva
  import atf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic standbyState,
  input wire logic slaveDiagFail,
  input wire atf_media_req_t mediaReq,
  input wire logic mediaReqValid,
  input wire atf_media_rsp_t mediaRsp,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Access phase qualifiers
  wire logic accPh = psel && penable;
  wire logic opWr = accPh && pwrite && pstrb[0] && paddr == OFF_OPCODE;
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_req_pulse: assert property (mediaReqValid |=> !mediaReqValid)
    else $error("media request longer than one cycle");
  a_req_cause: assert property
    (mediaReqValid |-> $past(opWr, 2) || $past(opWr, 3))
    else $error("media request without opcode write");
  a_unmapped_err: assert property (accPh && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access without pslverr");
  a_mapped_ok: assert property
    (accPh && paddr <= 8'h30 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access with pslverr");
  a_opcode_zero: assert property
    (accPh && !pwrite && paddr == OFF_OPCODE |-> prdata == 32'h0)
    else $error("opcode register reads nonzero");
  a_upper_zero: assert property
    (accPh && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read data nonzero");
  a_irq_hold: assert property (irq && !(accPh && pwrite) |=> irq)
    else $error("interrupt dropped without a write");
  a_irq_mask: assert property (accPh && pwrite && pstrb[0] &&
    paddr == OFF_IRQEN && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt high with all enables off");
  c_media: cover property (mediaReqValid);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (accPh && pslverr);
endmodule

bind atf_cmd_handler atf_cmd_handler_sva atf_cmd_handler_sva_inst (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .standbyState(standbyState), .slaveDiagFail(slaveDiagFail),
  .mediaReq(mediaReq), .mediaReqValid(mediaReqValid),
  .mediaRsp(mediaRsp), .irq(irq));

// File: tb/atf_media_model.sv
// Media engine model: one done pulse per request after a set delay.
// Delay, fault and diagnostic code are set by the bench.
`timescale 1ns/1ps
module atf_media_model
  import atf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mediaReqValid,
  input wire atf_media_req_t mediaReq,
  input wire logic [7:0] latency,
  input wire logic faultIn,
  input wire logic [7:0] codeIn,
  output atf_media_rsp_t mediaRsp
);
  logic busy_reg;
  logic [7:0] waitCnt_reg;
  // Erase and flush take media time before done
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      waitCnt_reg <= 8'h00;
    end else if (mediaReqValid) begin
      busy_reg <= 1'b1;
      waitCnt_reg <= latency;
    end else if (busy_reg) begin
      busy_reg <= waitCnt_reg != 8'h00;
      waitCnt_reg <= waitCnt_reg - 8'h01;
    end
  end
  // Outside done the fields carry junk, so stale values cannot pass
  assign mediaRsp.done = busy_reg && waitCnt_reg == 8'h00;
  assign mediaRsp.fault = mediaRsp.done ? faultIn : ~faultIn;
  assign mediaRsp.diagCode = mediaRsp.done ? codeIn : ~codeIn;
endmodule

// File: tb/ata_task_file_command_handler_test.sv
// Testbench for the command handler with an APB host and media model.
// Assumes package offsets and the handler's default parameters.
`timescale 1ns/1ps
module ata_task_file_command_handler_test import atf_pkg::*;;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pslverr, pready, irq, mediaReqValid, errSeen;
  logic standbyState = 1'b0, slaveDiagFail = 1'b0, faultIn = 1'b0;
  logic [7:0] paddr = 8'h00, latency = 8'h05, codeIn = 8'h01;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  atf_media_req_t mediaReq, seenReq;
  atf_media_rsp_t mediaRsp;
  int error_cnt = 0, n_compared = 0;
  atf_cmd_handler atf_cmd_handler_inst (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standbyState(standbyState),
    .slaveDiagFail(slaveDiagFail), .mediaReq(mediaReq),
    .mediaReqValid(mediaReqValid), .mediaRsp(mediaRsp), .irq(irq));
  atf_media_model atf_media_model_inst (.clk_sys(clk_sys), .nrst(nrst),
    .mediaReqValid(mediaReqValid), .mediaReq(mediaReq),
    .latency(latency), .faultIn(faultIn), .codeIn(codeIn),
    .mediaRsp(mediaRsp));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Keep the last media request for inspection
  always @(posedge clk_sys) if (mediaReqValid === 1'b1) seenReq <= mediaReq;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; read data and pslverr taken at the pready edge
  task automatic apb(input logic [7:0] a, input logic w, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op);
    apb(OFF_IRQCLR, 1'b1, 32'h7);
    apb(OFF_OPCODE, 1'b1, {24'h0, op});
    for (int i = 0; i < 60; i++) begin
      apb(OFF_STATUS, 1'b0, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    // A command that never ends must not slip through as a pass
    chk("idle", {31'h0, rd[ST_BUSY]}, 32'h0);
  endtask
  task automatic t_power;
    for (int i = 0; i < 4; i++) begin
      standbyState <= i[0];
      apb(OFF_SECCNT, 1'b1, 32'h5a);
      cmd(i[1] ? OP_PWR_B : OP_PWR_A);
      apb(OFF_SECCNT, 1'b0, 32'h0);
      chk("seccnt", rd, i[0] ? 32'h0 : 32'hff);
      chk("irq", {31'h0, irq}, 32'h1);
    end
  endtask
  task automatic t_erase;
    apb(OFF_SECNUM, 1'b1, 32'h11);
    apb(OFF_CYLLOW, 1'b1, 32'h22);
    apb(OFF_CYLHIGH, 1'b1, 32'h33);
    apb(OFF_DRVHEAD, 1'b1, 32'h45);
    apb(OFF_SECCNT, 1'b1, 32'h08);
    apb(OFF_FEATURE, 1'b1, 32'ha5);
    for (int f = 0; f < 2; f++) begin
      faultIn <= f[0];
      cmd(OP_ERASE);
      chk("lba", {4'h0, seenReq.lba}, 32'h05332211);
      chk("count", {24'h0, seenReq.count}, 32'h8);
      chk("lbamode", {31'h0, seenReq.lbaMode}, 32'h1);
      chk("op", {30'h0, seenReq.op}, {30'h0, ATF_MOP_ERASE});
      chk("fault", {31'h0, rd[ST_WF]}, f);
    end
    faultIn <= 1'b0;
  endtask
  // Drive bit set: diagnostics must still run
  task automatic t_diag;
    apb(OFF_DRVHEAD, 1'b1, 32'h10);
    for (int c = 1; c < 7; c++) begin
      codeIn <= (c == 6) ? 8'h01 : c[7:0];
      slaveDiagFail <= (c == 6);
      cmd(OP_DIAG);
      apb(OFF_ERROR, 1'b0, 32'h0);
      chk("diag", rd, (c == 6) ? 32'h81 : c);
    end
    slaveDiagFail <= 1'b0;
    apb(OFF_DRVHEAD, 1'b1, 32'h0);
  endtask
  // Long media time shows busy is held until the cache is written
  task automatic t_flush;
    latency <= 8'd40;
    apb(OFF_OPCODE, 1'b1, {24'h0, OP_FLUSH});
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("busy", {31'h0, rd[ST_BUSY]}, 32'h1);
    cmd(8'h00);
    apb(OFF_OPCODE, 1'b1, {24'h0, OP_FLUSH});
    cmd(OP_FLUSH);
    chk("rdydsc", {30'h0, rd[ST_RDY], rd[ST_DSC]}, 32'h3);
    chk("noabort", {31'h0, rd[ST_ERR]}, 32'h0);
    chk("op", {30'h0, seenReq.op}, {30'h0, ATF_MOP_FLUSH});
    // Idle now, so this opcode is taken and must end as aborted
    cmd(8'h00);
    chk("aborterr", {31'h0, rd[ST_ERR]}, 32'h1);
    apb(OFF_ERROR, 1'b0, 32'h0);
    chk("abortcode", rd, 32'h4);
  endtask
  task automatic t_ident;
    logic [15:0] w [256];
    cmd(OP_IDENT);
    chk("drq", {31'h0, rd[ST_DRQ]}, 32'h1);
    for (int i = 0; i < 256; i++) begin
      apb(OFF_DATA, 1'b0, 32'h0);
      w[i] = rd[15:0];
    end
    chk("cfg", {16'h0, w[0]}, 32'h044a);
    chk("cap", {w[7], w[8]}, 32'h00100000);
    chk("rsv", {w[2], w[77]}, 32'h0);
    for (int i = 69; i < 76; i++) chk("rsv", {16'h0, w[i]}, 32'h0);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("drqoff", {31'h0, rd[ST_DRQ]}, 32'h0);
    apb(OFF_DATA, 1'b0, 32'h0);
    chk("nodata", rd, 32'h0);
    apb(OFF_IRQEN, 1'b1, 32'h0);
    @(negedge clk_sys);
    chk("masked", {31'h0, irq}, 32'h0);
    apb(OFF_IRQEN, 1'b1, 32'h7);
    @(negedge clk_sys);
    chk("unmask", {31'h0, irq}, 32'h1);
    apb(OFF_IRQCLR, 1'b1, 32'h7);
    @(negedge clk_sys);
    chk("cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #3000000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("status", rd, 32'h50);
    apb(8'h40, 1'b0, 32'h0);
    chk("slverr", {31'h0, errSeen}, 32'h1);
    apb(OFF_IRQEN, 1'b1, 32'h7);
    t_power;
    t_erase;
    t_diag;
    t_flush;
    t_ident;
    stop_test;
  end
endmodule
